// ### bench/host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_bus_model
(
    // clock
    input  wire logic        clk,
    // wishbone master side
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [5:0]       adr,
    output logic [3:0]       sel,
    output logic [31:0]      dat,
    input  wire logic [31:0] datIn,
    input  wire logic        ack
);
    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we  = 1'b0;
        adr = 6'h00;
        sel = 4'h0;
        dat = 32'h00000000;
    end

    // one classic cycle; the wait is bounded so a dead slave cannot hang the run
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic lost);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= wd;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rd = datIn;
        lost = (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        dat <= ~wd;
    endtask
endmodule
`default_nettype wire

// ### bench/wake_relay_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module wake_relay_timer_bench
    import wake_timer_pkg::*;
;
    logic        clk, rst_n, stbyRst_n, wakePin, keyPin, timerEnablePin, relayFault;
    logic        mainRelayOut, startUpReq, cyc, stb, we, ack;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] datW, datR, d, e;
    int          errorCnt, checkCount;

    wake_relay_timer #(.WkFiltCyc(8), .RelayOffCyc(16), .TickCyc(4)) i_dut (
        .clk(clk), .rst_n(rst_n), .stbyRst_n(stbyRst_n), .wakePin(wakePin),
        .keyPin(keyPin), .timerEnablePin(timerEnablePin), .relayFault(relayFault),
        .mainRelayOut(mainRelayOut), .startUpReq(startUpReq), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack));

    host_bus_model i_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .dat(datW), .datIn(datR), .ack(ack));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        logic lost;
        i_host.xfer(w, a, wd, rd, lost);
        if (lost)
        begin
            errorCnt++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] wd);
        logic [31:0] x;
        bus(1'b1, a, wd, x);
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] x);
        bus(1'b0, a, 32'h00000000, x);
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask

    // polls a register until the masked value appears; giving up ends the run
    task automatic poll(input logic [5:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        logic [31:0] x;
        n = 0;
        do
        begin
            rd(a, x);
            n++;
        end
        while ((x & m) !== v && n < 3000);
        check(x & m, v);
        if ((x & m) !== v)
            print_verdict();
    endtask

    initial
    begin
        rst_n = 1'b0;
        stbyRst_n = 1'b0;
        wakePin = 1'b0;
        keyPin = 1'b0;
        timerEnablePin = 1'b1;
        relayFault = 1'b0;
        errorCnt = 0;
        checkCount = 0;
        ticks(4);
        rst_n <= 1'b1;
        stbyRst_n <= 1'b1;
        ticks(1);
        rd(ADR_STAT1, d);
        check(d, 32'h00000001);
        rd(ADR_CNTALL, d);
        check(d, {8'h00, RST_CNT});
        rd(ADR_THRLO, d);
        check(d, 32'h00000000);
        rd(ADR_CFG, d);
        check(d, {31'h0, RST_SRC});
        wr(6'h3c, 32'hffffffff);
        rd(6'h3c, d);
        check(d, 32'h00000000);
        rd(ADR_STAT0, d);
        check(d, 32'h00000000);
        $display("test reset values done");
        // a pulse shorter than the filter must not pass
        wakePin <= 1'b1;
        ticks(3);
        wakePin <= 1'b0;
        ticks(20);
        rd(ADR_STAT0, d);
        check(d & 32'h3, 32'h0);
        wakePin <= 1'b1;
        poll(ADR_STAT0, 32'h3, 32'h3);
        check({31'h0, startUpReq}, 32'h1);
        wakePin <= 1'b0;
        ticks(3);
        wakePin <= 1'b1;
        ticks(20);
        rd(ADR_STAT0, d);
        check(d & 32'h1, 32'h1);
        wr(ADR_CMD, 32'h1 << BIT_WAKE_CLEAR_CMD_BIT);
        ticks(40);
        rd(ADR_STAT0, d);
        check(d & 32'h3, 32'h1);
        check({31'h0, startUpReq}, 32'h0);
        wakePin <= 1'b0;
        poll(ADR_STAT0, 32'h3, 32'h0);
        wakePin <= 1'b1;
        poll(ADR_STAT0, 32'h3, 32'h3);
        wr(ADR_CMD, 32'h1 << BIT_WAKE_CLEAR_CMD_BIT);
        wakePin <= 1'b0;
        poll(ADR_STAT0, 32'h3, 32'h0);
        $display("test wake done");
        wr(ADR_CMD, 32'h1 << BIT_RELAY);
        ticks(3);
        check({31'h0, mainRelayOut}, 32'h1);
        rd(ADR_STAT0, d);
        check(d & 32'h4, 32'h4);
        relayFault <= 1'b1;
        ticks(6);
        check({31'h0, mainRelayOut}, 32'h0);
        relayFault <= 1'b0;
        ticks(8);
        check({31'h0, mainRelayOut}, 32'h0);
        poll(ADR_STAT0, 32'h4, 32'h4);
        wr(ADR_CMD, 32'h0);
        ticks(3);
        check({31'h0, mainRelayOut}, 32'h0);
        keyPin <= 1'b1;
        ticks(8);
        check({31'h0, mainRelayOut}, 32'h1);
        keyPin <= 1'b0;
        ticks(8);
        check({31'h0, mainRelayOut}, 32'h0);
        $display("test relay done");
        rd(ADR_STAT1, d);
        check(d, 32'h0);
        rd(ADR_CNTALL, d);
        check(d & 32'hffff00, 32'h0);
        ticks(12);
        rd(ADR_CNTALL, e);
        check({31'h0, e > d}, 32'h1);
        timerEnablePin <= 1'b0;
        ticks(8);
        rd(ADR_CNTALL, d);
        ticks(40);
        rd(ADR_CNTALL, e);
        check(e, d);
        timerEnablePin <= 1'b1;
        poll(ADR_CNTALL, 32'hff00, 32'h100);
        rd(ADR_CNT1, d);
        check(d, 32'h1);
        $display("test counter done");
        // restart before arming the threshold, else the running count matches at once
        wr(ADR_CFG, 32'h1 << BIT_SRC);
        wr(ADR_CMD, 32'h1 << BIT_TSTART);
        wr(ADR_THRLO, 32'h1);
        wr(ADR_THRHI, 32'h0);
        rd(ADR_THRLO, d);
        check(d, 32'h1);
        rd(ADR_CNTALL, d);
        check(d & 32'hffff00, 32'h0);
        rd(ADR_STAT0, d);
        check(d & 32'h8, 32'h0);
        poll(ADR_STAT0, 32'h8, 32'h8);
        rd(ADR_CNTALL, d);
        check(d & 32'hffff00, 32'h100);
        check({31'h0, startUpReq}, 32'h1);
        wr(ADR_CMD, 32'h1 << BIT_WAKE_CLEAR_CMD_BIT);
        rd(ADR_STAT0, d);
        check(d & 32'h8, 32'h8);
        poll(ADR_CNTALL, 32'hff00, 32'h200);
        wr(ADR_CMD, 32'h1 << BIT_WAKE_CLEAR_CMD_BIT);
        rd(ADR_STAT0, d);
        check(d & 32'h8, 32'h0);
        $display("test comparator done");
        rd(ADR_CNTALL, d);
        rst_n <= 1'b0;
        ticks(2);
        rst_n <= 1'b1;
        // the enable pin must resynchronise before the counter moves again
        ticks(20);
        rd(ADR_CNTALL, e);
        check({31'h0, e > d}, 32'h1);
        rd(ADR_THRLO, d);
        check(d, 32'h0);
        stbyRst_n <= 1'b0;
        ticks(2);
        stbyRst_n <= 1'b1;
        ticks(1);
        rd(ADR_CNTALL, d);
        check(d, 32'h0);
        ticks(20);
        rd(ADR_CNTALL, d);
        check(d, 32'h0);
        rd(ADR_STAT1, d);
        check(d, 32'h1);
        wr(ADR_CFG, 32'h1 << BIT_SRC);
        wr(ADR_CMD, 32'h1 << BIT_TSTART);
        rd(ADR_STAT1, d);
        check(d, 32'h0);
        poll(ADR_CNTALL, 32'hff00, 32'h100);
        rd(ADR_STAT0, d);
        check(d & 32'h8, 32'h0);
        $display("test resets done");
        print_verdict();
    end
endmodule
`default_nettype wire

// ### common/wake_timer_pkg.sv
package wake_timer_pkg;
    // register byte addresses
    localparam logic [5:0] ADR_CMD    = 6'h00;
    localparam logic [5:0] ADR_CFG    = 6'h04;
    localparam logic [5:0] ADR_THRLO  = 6'h08;
    localparam logic [5:0] ADR_THRHI  = 6'h0c;
    localparam logic [5:0] ADR_STAT0  = 6'h10;
    localparam logic [5:0] ADR_STAT1  = 6'h14;
    localparam logic [5:0] ADR_CNT0   = 6'h18;
    localparam logic [5:0] ADR_CNT1   = 6'h1c;
    localparam logic [5:0] ADR_CNT2   = 6'h20;
    localparam logic [5:0] ADR_CNTALL = 6'h24;
    // command register bits
    localparam int BIT_WAKE_CLEAR_CMD_BIT  = 0;
    localparam int BIT_RELAY  = 1;
    localparam int BIT_TSTART = 2;
    // configuration register bit
    localparam int BIT_SRC    = 0;
    // reset values and counter full scale
    localparam logic        RST_SRC   = 1'b0;
    localparam logic        RST_RELAY = 1'b0;
    localparam logic [15:0] RST_THR   = 16'h0000;
    localparam logic [23:0] RST_CNT   = 24'h000000;
    localparam logic [23:0] CNT_FULL  = 24'hffffff;
    // timing
    localparam int CLK_NS         = 4;
    localparam int WK_FILT_NS     = 2000000;
    localparam int RELAY_OFF_NS   = 16000000;
    localparam int TICK_NS        = 1000000000 / 128;
    localparam int WK_FILT_CYC    = WK_FILT_NS / CLK_NS;
    localparam int RELAY_OFF_CYC  = (RELAY_OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_CYC       = TICK_NS / CLK_NS;

    typedef struct packed {
        logic timerWake;
        logic relay;
        logic wakeLatch;
        logic wakeLevel;
    } op_stat0_t;

    typedef enum logic [2:0] {
        WK_IDLE    = 3'b001,
        WK_ACTIVE  = 3'b010,
        WK_CLEARED = 3'b100
    } wk_state_t;
endpackage

// ### core/wake_relay_timer.sv
// Overview of operation
// - filtered wake high starts the device start-up request
// - wake pin deglitched on both edges; filtered level readable
// - filtered rising edge sets internal wake latch, readable
// - wake-clear command clears the latch; host uses it for sleep
// - cleared latch stays clear while the pin stays high
// - filtered low returns wake machine to inactive, arming next edge
// - key low: relay follows command bit; key high: relay on; readable
// - fault switches relay off, back on after release, minimum off time
// - engine-off timer works only with its enable pin high
// - nonzero threshold enables comparator; zero means count only
// - counter equal to threshold sets timer wake flag, readable
// - wake-clear clears timer flag only while counter differs
// - config bit picks start source: key fall (reset) or command
// - start event clears counter and starts counting
// - standby reset flag clears at counter start; host reads first
// - standby ramp resets counter and threshold, sets standby flag
// - 24-bit count readable in three registers and one multi-read
// - reads and wake-ups never pause or alter the counter
// - main reset leaves counter alone but clears threshold
// - counter saturates at full scale; standby reset zeroes it
// - one increment per 1/128 s tick, 24 bits wide
// - wake filter interval nominally 2 ms
// - relay stays off at least 16 ms after a fault switch-off
// - 16-bit threshold, 2 s per step, nonzero enables compare
`timescale 1ns/10ps
`default_nettype none
module wake_relay_timer
    import wake_timer_pkg::*;
#(
    parameter int WkFiltCyc   = WK_FILT_CYC,
    parameter int RelayOffCyc = RELAY_OFF_CYC,
    parameter int TickCyc     = TICK_CYC
)(
    // clock and resets
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        stbyRst_n,
    // pins
    input  wire logic        wakePin,
    input  wire logic        keyPin,
    input  wire logic        timerEnablePin,
    input  wire logic        relayFault,
    output logic             mainRelayOut,
    output logic             startUpReq,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);
    // pin synchronisers: bit 0 wake, 1 key, 2 enable, 3 fault
    logic [3:0]  pinS1_r;
    logic [3:0]  pinS2_r;
    logic [3:0]  pinS3_r;
    logic [3:0]  pinLvl_r;
    logic        wkFilt_r;
    logic [19:0] wkFiltCnt_r;
    wk_state_t   wkState_r;
    logic        wkLatch_r;
    logic        relayCmd_r;
    logic        relayOut_r;
    logic        faultOff_r;
    logic [22:0] offCnt_r;
    logic        srcCmd_r;
    logic [15:0] thr_r;
    logic [23:0] cnt_r;
    logic        running_r;
    logic [21:0] tickCnt_r;
    logic        tick;
    logic        timerFlag_r;
    logic        stbyFlag_r;
    logic        keyPrev_r;
    logic        wbAck_r;
    logic [31:0] wbDat_r;
    logic        wbReq;
    logic        wbWrite;
    logic        cmdWr;
    logic        wkClear;
    logic        startCmd;
    logic        keyFall;
    logic        startEv;
    logic        cmpOn;
    logic        match;
    logic        thrRst_n;
    op_stat0_t   stat0;

    function automatic logic regHit(input logic [5:0] adr, input logic [5:0] ref_);
        regHit = (adr[5:2] == ref_[5:2]);
    endfunction

    assign wbReq    = wb_cyc_i & wb_stb_i;
    // a write lands on the edge where ack is seen high
    assign wbWrite  = wbReq & wb_we_i & wbAck_r & wb_sel_i[0];
    assign cmdWr    = wbWrite & regHit(wb_adr_i, ADR_CMD);
    assign wkClear  = cmdWr & wb_dat_i[BIT_WAKE_CLEAR_CMD_BIT];
    assign startCmd = cmdWr & wb_dat_i[BIT_TSTART];
    assign keyFall  = keyPrev_r & ~pinLvl_r[1];
    assign startEv  = srcCmd_r ? startCmd : keyFall;
    assign cmpOn    = (thr_r != RST_THR);
    // threshold step is 256 counter ticks
    assign match    = (cnt_r[23:8] == thr_r);
    assign tick     = (tickCnt_r == 22'(TickCyc - 1));
    assign thrRst_n = rst_n & stbyRst_n;

    // a pin change is accepted once stages two and three agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinS1_r  <= 4'h0;
            pinS2_r  <= 4'h0;
            pinS3_r  <= 4'h0;
            pinLvl_r <= 4'h0;
            keyPrev_r <= 1'b0;
        end
        else
        begin
            pinS1_r  <= {relayFault, timerEnablePin, keyPin, wakePin};
            pinS2_r  <= pinS1_r;
            pinS3_r  <= pinS2_r;
            pinLvl_r <= (pinS2_r & pinS3_r) | (pinLvl_r & (pinS2_r | pinS3_r));
            keyPrev_r <= pinLvl_r[1];
        end
    end

    // deglitch both edges; level must hold the whole interval
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wkFilt_r    <= 1'b0;
            wkFiltCnt_r <= 20'h00000;
        end
        else if (pinLvl_r[0] == wkFilt_r)
            wkFiltCnt_r <= 20'h00000;
        else if (wkFiltCnt_r == 20'(WkFiltCyc - 1))
        begin
            wkFilt_r    <= pinLvl_r[0];
            wkFiltCnt_r <= 20'h00000;
        end
        else
            wkFiltCnt_r <= wkFiltCnt_r + 20'h00001;
    end

    // wake state machine
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wkState_r <= WK_IDLE;
            wkLatch_r <= 1'b0;
        end
        else
        begin
            case (wkState_r)
                WK_IDLE:
                begin
                    if (wkFilt_r)
                    begin
                        wkState_r <= WK_ACTIVE;
                        wkLatch_r <= 1'b1;
                    end
                end
                WK_ACTIVE:
                begin
                    if (!wkFilt_r)
                    begin
                        wkState_r <= WK_IDLE;
                        wkLatch_r <= 1'b0;
                    end
                    else if (wkClear)
                    begin
                        wkState_r <= WK_CLEARED;
                        wkLatch_r <= 1'b0;
                    end
                end
                WK_CLEARED:
                begin
                    if (!wkFilt_r)
                        wkState_r <= WK_IDLE;
                end
                default:
                begin
                    wkState_r <= WK_IDLE;
                    wkLatch_r <= 1'b0;
                end
            endcase
        end
    end

    // start-up request from either wake source
    assign startUpReq = wkLatch_r | timerFlag_r;

    // relay command and start source configuration
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            relayCmd_r <= RST_RELAY;
            srcCmd_r   <= RST_SRC;
        end
        else
        begin
            if (cmdWr)
                relayCmd_r <= wb_dat_i[BIT_RELAY];
            if (wbWrite && regHit(wb_adr_i, ADR_CFG))
                srcCmd_r <= wb_dat_i[BIT_SRC];
        end
    end

    // fault forces off; off interval restarts on each switch-off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            faultOff_r <= 1'b0;
            offCnt_r   <= 23'h000000;
        end
        else if (pinLvl_r[3])
        begin
            faultOff_r <= 1'b1;
            if (!faultOff_r)
                offCnt_r <= 23'(RelayOffCyc - 1);
            else if (offCnt_r != 23'h000000)
                offCnt_r <= offCnt_r - 23'h000001;
        end
        else if (offCnt_r != 23'h000000)
            offCnt_r <= offCnt_r - 23'h000001;
        else
            faultOff_r <= 1'b0;
    end

    // key high wins; otherwise the host command decides
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            relayOut_r <= 1'b0;
        else
            relayOut_r <= (pinLvl_r[1] | relayCmd_r) & ~faultOff_r & ~pinLvl_r[3];
    end
    assign mainRelayOut = relayOut_r;

    // either reset clears threshold; low-byte writes
    always_ff @(posedge clk or negedge thrRst_n)
    begin
        if (!thrRst_n)
            thr_r <= RST_THR;
        else if (wbWrite && regHit(wb_adr_i, ADR_THRLO))
            thr_r[7:0] <= wb_dat_i[7:0];
        else if (wbWrite && regHit(wb_adr_i, ADR_THRHI))
            thr_r[15:8] <= wb_dat_i[7:0];
    end

    // prescaler runs only when enabled; standby reset clears it, main reset clears it through the reset enable synchroniser
    always_ff @(posedge clk or negedge stbyRst_n)
    begin
        if (!stbyRst_n)
            tickCnt_r <= 22'h000000;
        else if (!pinLvl_r[2] || startEv || tick)
            tickCnt_r <= 22'h000000;
        else if (running_r)
            tickCnt_r <= tickCnt_r + 22'h000001;
    end

    // start clears and runs; saturate, standby zeroes
    // one count per tick; bus reads never touch this
    always_ff @(posedge clk or negedge stbyRst_n)
    begin
        if (!stbyRst_n)
        begin
            cnt_r     <= RST_CNT;
            running_r <= 1'b0;
        end
        else if (pinLvl_r[2] && startEv)
        begin
            cnt_r     <= RST_CNT;
            running_r <= 1'b1;
        end
        else if (pinLvl_r[2] && running_r && tick && cnt_r != CNT_FULL)
            cnt_r <= cnt_r + 24'h000001;
    end

    // set by standby ramp; cleared by counter start
    always_ff @(posedge clk or negedge stbyRst_n)
    begin
        if (!stbyRst_n)
            stbyFlag_r <= 1'b1;
        else if (pinLvl_r[2] && startEv)
            stbyFlag_r <= 1'b0;
    end

    // match sets the flag; set wins over a clear
    // clear only honoured while no match
    always_ff @(posedge clk or negedge stbyRst_n)
    begin
        if (!stbyRst_n)
            timerFlag_r <= 1'b0;
        else if (pinLvl_r[2] && cmpOn && match)
            timerFlag_r <= 1'b1;
        else if (wkClear && !match)
            timerFlag_r <= 1'b0;
    end

    assign stat0 = {timerFlag_r, relayOut_r, wkLatch_r, wkFilt_r};

    // read data is captured with the ack so it stands while ack is high
    // three count bytes plus one combined word
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wbAck_r <= 1'b0;
            wbDat_r <= 32'h00000000;
        end
        else
        begin
            wbAck_r <= wbReq & ~wbAck_r;
            if (wbReq && !wbAck_r)
            begin
                case (wb_adr_i[5:2])
                    ADR_CMD[5:2]:    wbDat_r <= {30'h0, relayCmd_r, 1'b0};
                    ADR_CFG[5:2]:    wbDat_r <= {31'h0, srcCmd_r};
                    ADR_THRLO[5:2]:  wbDat_r <= {24'h0, thr_r[7:0]};
                    ADR_THRHI[5:2]:  wbDat_r <= {24'h0, thr_r[15:8]};
                    ADR_STAT0[5:2]:  wbDat_r <= {28'h0, stat0};
                    ADR_STAT1[5:2]:  wbDat_r <= {31'h0, stbyFlag_r};
                    ADR_CNT0[5:2]:   wbDat_r <= {24'h0, cnt_r[7:0]};
                    ADR_CNT1[5:2]:   wbDat_r <= {24'h0, cnt_r[15:8]};
                    ADR_CNT2[5:2]:   wbDat_r <= {24'h0, cnt_r[23:16]};
                    ADR_CNTALL[5:2]: wbDat_r <= {8'h0, cnt_r};
                    default:         wbDat_r <= 32'h00000000;
                endcase
            end
        end
    end
    assign wb_ack_o = wbAck_r;
    assign wb_dat_o = wbDat_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n || !stbyRst_n);

    a_relay_key: assert property (
        (pinLvl_r[1] && !faultOff_r && !pinLvl_r[3]) |=> relayOut_r)
        else $error("relay off while key high and no fault");
    a_relay_fault: assert property (
        $rose(pinLvl_r[3]) |=> !relayOut_r [*2])
        else $error("relay on during fault");
    a_relay_offmin: assert property (
        (faultOff_r && offCnt_r != 23'h000000) |=> !relayOut_r)
        else $error("relay on inside minimum off time");
    a_latch_set: assert property (
        (wkState_r == WK_IDLE && wkFilt_r) |=> (wkLatch_r && wkState_r == WK_ACTIVE))
        else $error("wake edge did not set latch");
    a_latch_clear: assert property (
        (wkState_r == WK_ACTIVE && wkFilt_r && wkClear) |=> !wkLatch_r ##1 !wkLatch_r)
        else $error("wake clear did not clear latch");
    a_latch_hold: assert property (
        (wkState_r == WK_CLEARED && wkFilt_r) |=> !wkLatch_r)
        else $error("held pin retriggered wake");
    a_wake_rearm: assert property (
        (wkState_r != WK_IDLE && !wkFilt_r) |=> wkState_r == WK_IDLE)
        else $error("low pin did not rearm wake");
    a_filter_hold: assert property (
        $changed(wkFilt_r) |-> $past(pinLvl_r[0]) == wkFilt_r)
        else $error("filtered wake changed without pin");
    a_cmp_off: assert property (
        (!cmpOn && !timerFlag_r) |=> !timerFlag_r)
        else $error("timer wake with zero threshold");
    a_cmp_match: assert property (
        (pinLvl_r[2] && cmpOn && match) |=> timerFlag_r)
        else $error("match did not set timer wake");
    a_flag_keep: assert property (
        (timerFlag_r && match) |=> timerFlag_r)
        else $error("timer wake cleared during match");
    a_start_clear: assert property (
        (pinLvl_r[2] && startEv) |=> (cnt_r == RST_CNT && !stbyFlag_r && running_r))
        else $error("start did not clear counter and flag");
    a_count_sat: assert property (
        (cnt_r == CNT_FULL && !(pinLvl_r[2] && startEv)) |=> cnt_r == CNT_FULL)
        else $error("counter left full scale");
    a_count_step: assert property (
        (!tick && !(pinLvl_r[2] && startEv)) |=> $stable(cnt_r))
        else $error("counter moved without a tick");
endmodule
`default_nettype wire
